// ---- mmcr_top.sv ----
/*
  memory map control register with write protect and map decode.
  assumes classic wishbone with 32-bit data, cpu address 20 bits.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
module mmcr_top
  import mmcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cpu address decode
  input wire logic [19:0] cpu_adr,
  input wire logic flash_version,
  output logic cs3_area_hit,
  output logic blk_a_enabled,
  output logic int_ram_hit,
  output logic int_rom_hit,
  output logic ext_usable,
  output logic ext_reserved,
  // internal access wait
  input wire logic int_req,
  output logic int_rdy
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic prot_r;
  logic prot_nxt;

  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr_lane0 = req && wb_we_i && wb_sel_i[0];
  wire sel_mode = (wb_adr_i == MMCR_ADR_MODE_CTRL);
  wire sel_prot = (wb_adr_i == MMCR_ADR_PROTECT);
  wire sel_stat = (wb_adr_i == MMCR_ADR_MAP_STAT);
  wire area_sw = mode_r[MMCR_BIT_AREA_SWITCH];
  wire expand = mode_r[MMCR_BIT_RSV_EXPAND];
  wire wait_en = mode_r[MMCR_BIT_INT_WAIT];

  wire mode_wr = wr_lane0 && sel_mode && prot_r;
  assign mode_nxt = mode_wr ?
    (wb_dat_i[7:0] & MMCR_MODE_WR_MASK) : mode_r;
  assign prot_nxt = (wr_lane0 && sel_prot) ?
    wb_dat_i[MMCR_BIT_WR_ENABLE] : prot_r;

  wire [7:0] stat_byte = {2'h0, ext_reserved, ext_usable, int_rom_hit,
    int_ram_hit, blk_a_enabled, cs3_area_hit};
  // unassigned bits read as fixed value
  wire [7:0] mode_rd = mode_r | (MMCR_UNDEF_READ & ~MMCR_MODE_WR_MASK);
  assign dat_nxt = !req ? dat_r :
    sel_mode ? {24'h0, mode_rd} :
    sel_prot ? {30'h0, prot_r, 1'b0} :
    sel_stat ? {24'h0, stat_byte} : MMCR_UNMAPPED_READ;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      mode_r <= MMCR_MODE_RST;
      prot_r <= 1'b0;
    end
    else
    begin
      ack_r <= req;
      dat_r <= dat_nxt;
      mode_r <= mode_nxt;
      prot_r <= prot_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------------------------------
  // map decode
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [19:0] a,
    input logic [19:0] lo, input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  wire [19:0] cs3_lo = area_sw ? MMCR_CS3_LO_WIDE : MMCR_CS3_LO_NARROW;
  assign cs3_area_hit = in_rng(cpu_adr, cs3_lo, MMCR_CS3_HI);
  assign blk_a_enabled = flash_version && area_sw &&
    in_rng(cpu_adr, MMCR_BLKA_LO, MMCR_BLKA_HI);
  wire ram_lim = in_rng(cpu_adr, MMCR_RAM_LO, MMCR_RAM_HI);
  wire rom_lim = (cpu_adr >= MMCR_ROM_LO);
  wire ext_rng = in_rng(cpu_adr, MMCR_EXT_LO_A, MMCR_EXT_HI_A) ||
    in_rng(cpu_adr, MMCR_EXT_LO_B, MMCR_EXT_HI_B);
  assign int_ram_hit = expand ? (cpu_adr < MMCR_EXT_LO_A) : ram_lim;
  assign int_rom_hit = expand ? (cpu_adr >= MMCR_EXT_LO_B) : rom_lim;
  assign ext_usable = ext_rng && !expand;
  assign ext_reserved = ext_rng && expand;

  // ----------------------------------------------------------------
  // wait inserter
  // ----------------------------------------------------------------
  mmcr_wait u_wait (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wait_en(wait_en),
    .int_req(int_req),
    .int_rdy(int_rdy)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_write_blocked: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req && wb_we_i && sel_mode && !prot_r |=> $stable(mode_r))
    else $error("mode register changed while protected");
  a_write_taken: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req && wb_we_i && wb_sel_i[0] && sel_mode && prot_r |=>
    mode_r == ($past(wb_dat_i[7:0]) & MMCR_MODE_WR_MASK))
    else $error("permitted write not stored");
  a_unassigned_zero: assert property (@(posedge core_clk)
    disable iff (!rst_n) (mode_r & ~MMCR_MODE_WR_MASK) == 8'h00)
    else $error("unassigned bit stored");
  a_area_start: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    cpu_adr == MMCR_CS3_LO_NARROW |-> cs3_area_hit == !area_sw)
    else $error("third area start wrong");
  a_ram_limit: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !expand && cpu_adr < MMCR_RAM_LO |-> !int_ram_hit)
    else $error("ram below limit used");
  a_ext_reserved: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    expand && cpu_adr == MMCR_EXT_LO_B |-> ext_reserved && !ext_usable)
    else $error("external range not reserved");
  a_ext_usable: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !expand && cpu_adr == MMCR_EXT_HI_A |-> ext_usable)
    else $error("external range not usable");
  a_block_enable: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    cpu_adr == MMCR_BLKA_LO |-> blk_a_enabled == (area_sw && flash_version))
    else $error("small block enable wrong");
  a_ack_one: assert property (@(posedge core_clk)
    disable iff (!rst_n) wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (@(posedge core_clk)
    disable iff (!rst_n) req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_prot_store: assert property (@(posedge core_clk)
    disable iff (!rst_n) wr_lane0 && sel_prot |=>
    prot_r == $past(wb_dat_i[MMCR_BIT_WR_ENABLE]))
    else $error("write enable bit not stored");
  a_area_end: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    cpu_adr == MMCR_CS3_HI |-> cs3_area_hit)
    else $error("third area end not decoded");
  a_area_above: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    cpu_adr > MMCR_CS3_HI |-> !cs3_area_hit)
    else $error("third area decoded above its end");
  a_area_wide: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    area_sw && cpu_adr < MMCR_CS3_LO_WIDE |-> !cs3_area_hit)
    else $error("third area start not moved");
  a_rom_limit: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !expand && cpu_adr < MMCR_ROM_LO |-> !int_rom_hit)
    else $error("rom below limit used");
  a_ram_whole: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    expand && cpu_adr < MMCR_EXT_LO_A |-> int_ram_hit)
    else $error("internal ram not wholly usable");
  a_rom_whole: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    expand && cpu_adr >= MMCR_EXT_LO_B |-> int_rom_hit)
    else $error("internal rom not wholly usable");
  a_ext_low_usable: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !expand && cpu_adr == MMCR_EXT_LO_B |-> ext_usable && !ext_reserved)
    else $error("upper external range not usable");

  c_prot_write: cover property (@(posedge core_clk)
    disable iff (!rst_n) mode_wr);
  c_blocked_write: cover property (@(posedge core_clk)
    disable iff (!rst_n) req && wb_we_i && sel_mode && !prot_r);
  c_expand_on: cover property (@(posedge core_clk)
    disable iff (!rst_n) expand && ext_reserved);

endmodule : mmcr_top

// ---- mmcr_pkg.sv ----
/*
  package for the memory map control register block: offsets, bit
  positions, reset values and address bounds.
  assumes a 20-bit cpu address space and a 32-bit classic wishbone bus.
*/
package mmcr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MMCR_IDX_MODE_CTRL = 8'h05;
  localparam logic [7:0] MMCR_IDX_PROTECT = 8'h06;
  localparam logic [7:0] MMCR_IDX_MAP_STAT = 8'h07;
  localparam logic [9:0] MMCR_ADR_MODE_CTRL = 10'h014;
  localparam logic [9:0] MMCR_ADR_PROTECT = 10'h018;
  localparam logic [9:0] MMCR_ADR_MAP_STAT = 10'h01c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MMCR_BIT_AREA_SWITCH = 0;
  localparam int MMCR_BIT_RSV_EXPAND = 3;
  localparam int MMCR_BIT_INT_WAIT = 7;
  localparam int MMCR_BIT_WR_ENABLE = 1;
  localparam logic [7:0] MMCR_MODE_WR_MASK = 8'h8d;
  localparam logic [7:0] MMCR_MODE_RST = 8'h00;
  localparam logic [7:0] MMCR_UNDEF_READ = 8'h00;
  localparam logic [31:0] MMCR_UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // address bounds
  // ----------------------------------------------------------------
  localparam logic [19:0] MMCR_CS3_LO_NARROW = 20'h08000;
  localparam logic [19:0] MMCR_CS3_LO_WIDE = 20'h10000;
  localparam logic [19:0] MMCR_CS3_HI = 20'h26fff;
  localparam logic [19:0] MMCR_BLKA_LO = 20'h0f000;
  localparam logic [19:0] MMCR_BLKA_HI = 20'h0ffff;
  localparam logic [19:0] MMCR_RAM_LO = 20'h00400;
  localparam logic [19:0] MMCR_RAM_HI = 20'h03fff;
  localparam logic [19:0] MMCR_ROM_LO = 20'hd0000;
  localparam logic [19:0] MMCR_EXT_LO_A = 20'h04000;
  localparam logic [19:0] MMCR_EXT_HI_A = 20'h07fff;
  localparam logic [19:0] MMCR_EXT_LO_B = 20'h80000;
  localparam logic [19:0] MMCR_EXT_HI_B = 20'hcffff;
  localparam logic [1:0] MMCR_WAIT_CYCLES = 2'h1;

endpackage : mmcr_pkg

// ---- mmcr_wait.sv ----
/*
  internal access wait inserter: stretches each internal ram or rom
  access by one cycle when the wait bit is set.
  assumes int_req is held until int_rdy is seen high.
*/
`timescale 1ns/1ns
module mmcr_wait
  import mmcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic wait_en,
  // access handshake
  input wire logic int_req,
  output logic int_rdy
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  wire done = (cnt_r == MMCR_WAIT_CYCLES);

  assign cnt_nxt = (!int_req || int_rdy) ? 2'h0 :
                   done ? cnt_r : cnt_r + 2'h1;
  assign int_rdy = int_req && (!wait_en || done);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wait_one_cycle: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $rose(int_req) && wait_en |-> !int_rdy ##1 int_rdy)
    else $error("wait state not exactly one cycle");
  a_nowait_direct: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    int_req && !wait_en |-> int_rdy)
    else $error("access stalled without wait bit");
  c_wait_access: cover property (@(posedge core_clk)
    disable iff (!rst_n) int_rdy && wait_en);

endmodule : mmcr_wait

// ---- mmcr_top_tb.sv ----
/*
  testbench for mmcr_top: register access over wishbone and map decode.
  assumes the mmcr_pkg constants and a one-cycle registered ack.
*/
`timescale 1ns/1ns
module mmcr_top_tb
  import mmcr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic [19:0] cpu_adr = 20'h00000;
  logic flash_v = 1'b1;
  logic int_req = 1'b0;
  logic int_rdy;
  wire [5:0] map_o;
  logic [5:0] ex_map;
  logic [31:0] rd;
  logic [7:0] m;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] modes [4] = '{8'h00, 8'h01, 8'h08, 8'h09};
  logic [19:0] tab [15] = '{20'h003ff, 20'h00400, 20'h03fff, 20'h04000,
    20'h07fff, 20'h08000, 20'h0f000, 20'h0ffff, 20'h10000, 20'h26fff,
    20'h27000, 20'h80000, 20'hcffff, 20'hd0000, 20'hfffff};

  mmcr_top dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_adr(cpu_adr),
    .flash_version(flash_v), .cs3_area_hit(map_o[0]),
    .blk_a_enabled(map_o[1]), .int_ram_hit(map_o[2]),
    .int_rom_hit(map_o[3]), .ext_usable(map_o[4]),
    .ext_reserved(map_o[5]), .int_req(int_req), .int_rdy(int_rdy)
  );

  initial forever #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  task wb(input logic w, input logic [9:0] a, input logic [31:0] d,
          input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task map_chk(input logic [19:0] a);
    logic sw;
    logic ex;
    logic inx;
    sw = m[0];
    ex = m[3];
    inx = (a >= 20'h04000 && a <= 20'h07fff) ||
          (a >= 20'h80000 && a <= 20'hcffff);
    ex_map[0] = a >= (sw ? 20'h10000 : 20'h08000) && a <= 20'h26fff;
    ex_map[1] = flash_v && sw && a >= 20'h0f000 && a <= 20'h0ffff;
    ex_map[2] = ex ? a < 20'h04000 : a >= 20'h00400 && a <= 20'h03fff;
    ex_map[3] = a >= (ex ? 20'h80000 : 20'hd0000);
    ex_map[4] = inx && !ex;
    ex_map[5] = inx && ex;
    cpu_adr <= a;
    #1;
    chk("map", {26'h0, map_o}, {26'h0, ex_map});
    @(posedge core_clk);
  endtask : map_chk

  task rdy_chk(input logic w);
    wb(1'b1, MMCR_ADR_MODE_CTRL, {24'h0, w, 7'h0}, 4'h1);
    int_req <= 1'b1;
    #1;
    chk("rdy_first", {31'h0, int_rdy}, {31'h0, !w});
    @(posedge core_clk);
    #1;
    chk("rdy_next", {31'h0, int_rdy}, 32'h1);
    @(posedge core_clk);
    int_req <= 1'b0;
    @(posedge core_clk);
  endtask : rdy_chk

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, MMCR_ADR_MODE_CTRL, 32'h0, 4'h1);
    chk("mode_rst", rd, 32'h0);
    wb(1'b0, MMCR_ADR_PROTECT, 32'h0, 4'h1);
    chk("prot_rst", rd, 32'h0);
    wb(1'b1, MMCR_ADR_MODE_CTRL, 32'h89, 4'h1);
    wb(1'b0, MMCR_ADR_MODE_CTRL, 32'h0, 4'h1);
    chk("mode_locked", rd, 32'h0);
    wb(1'b1, MMCR_ADR_PROTECT, 32'h2, 4'h1);
    wb(1'b0, MMCR_ADR_PROTECT, 32'h0, 4'h1);
    chk("prot_set", rd, 32'h2);
    wb(1'b1, MMCR_ADR_MODE_CTRL, 32'h89, 4'h0);
    wb(1'b0, MMCR_ADR_MODE_CTRL, 32'h0, 4'h1);
    chk("mode_nolane", rd, 32'h0);
    wb(1'b1, MMCR_ADR_MODE_CTRL, 32'h89, 4'h1);
    wb(1'b0, MMCR_ADR_MODE_CTRL, 32'h0, 4'h1);
    chk("mode_open", rd, 32'h89);
    wb(1'b1, 10'h020, 32'hff, 4'h1);
    wb(1'b0, 10'h020, 32'h0, 4'h1);
    chk("unmapped", rd, 32'h0);
    rdy_chk(1'b1);
    rdy_chk(1'b0);
    foreach (modes[i])
    begin
      m = modes[i];
      wb(1'b1, MMCR_ADR_MODE_CTRL, {24'h0, m}, 4'h1);
      foreach (tab[j])
        map_chk(tab[j]);
      wb(1'b0, MMCR_ADR_MAP_STAT, 32'h0, 4'h1);
      chk("map_stat", rd, {26'h0, ex_map});
    end
    // mask rom keeps area bit 0
    m = 8'h08;
    wb(1'b1, MMCR_ADR_MODE_CTRL, {24'h0, m}, 4'h1);
    flash_v <= 1'b0;
    @(posedge core_clk);
    map_chk(20'h0f000);
    map_chk(20'h08000);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, MMCR_ADR_MODE_CTRL, 32'h0, 4'h1);
    chk("mode_rerst", rd, {24'h0, MMCR_MODE_RST});
    wb(1'b0, MMCR_ADR_PROTECT, 32'h0, 4'h1);
    chk("prot_rerst", rd, 32'h0);
    test_done;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    test_done;
  end
endmodule : mmcr_top_tb
